// ---- bench/pll_ratio_cfg_monitor.sv ----
// assertion checker for the ratio format and bandwidth block
`timescale 1ns/100ps
`default_nettype none
module pll_ratio_cfg_checker (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_auto_switch_en,
  input wire logic i_auto_hybrid_sel,
  input wire logic i_locked,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic [31:0] o_ratio_value,
  input wire logic [5:0] o_ratio_frac_bits,
  input wire logic o_hybrid_mode,
  input wire logic [2:0] o_input_loop_min_bandwidth,
  input wire logic [7:0] o_min_bandwidth_hz,
  input wire logic o_run_enable
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_read_answer_due: assert property (i_rd |=> o_rvalid) else $error("read not answered");
  a_unmapped_reads_zero: assert property (i_rd && i_addr == 8'hff |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reserved_read_zero: assert property (i_rd && i_addr == 8'h1e |=> o_rdata[7] == 1'b0 && o_rdata[3:0] == 4'h0)
    else $error("reserved bits not zero");
  a_static_frac_fixed: assert property (!o_hybrid_mode |-> o_ratio_frac_bits == 6'd20)
    else $error("static mode not 12.20");
  a_frac_two_codes: assert property (o_ratio_frac_bits == 6'd12 || o_ratio_frac_bits == 6'd20)
    else $error("bad fraction width");
  a_bw_hz_power: assert property (o_min_bandwidth_hz == (8'h01 << o_input_loop_min_bandwidth))
    else $error("bandwidth hz wrong");
  a_bw_held_locked: assert property (i_locked |=> $stable(o_input_loop_min_bandwidth))
    else $error("bandwidth changed while locked");
  a_auto_hybrid_mode: assert property ((i_auto_switch_en && i_auto_hybrid_sel) [*2] |-> o_hybrid_mode)
    else $error("auto hybrid not taken");
  a_run_after_write: assert property ($rose(o_run_enable) |-> $past(i_wr, 2))
    else $error("run enable without write");
endmodule : pll_ratio_cfg_checker
bind pll_ratio_format_and_bandwidth_cfg pll_ratio_cfg_checker i_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .i_auto_switch_en(i_auto_switch_en),
  .i_auto_hybrid_sel(i_auto_hybrid_sel), .i_locked(i_locked), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_ratio_value(o_ratio_value), .o_ratio_frac_bits(o_ratio_frac_bits), .o_hybrid_mode(o_hybrid_mode),
  .o_input_loop_min_bandwidth(o_input_loop_min_bandwidth), .o_min_bandwidth_hz(o_min_bandwidth_hz),
  .o_run_enable(o_run_enable));
`default_nettype wire

// ---- bench/pll_ratio_format_and_bandwidth_cfg_tb.sv ----
// self-checking bench for the ratio format and bandwidth block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module pll_ratio_format_and_bandwidth_cfg_tb;
  logic i_clk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, i_auto_switch_en = 0, i_auto_hybrid_sel = 0, i_locked = 0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, o_min_bandwidth_hz, seed = 8'h53;
  logic o_rvalid, o_hybrid_mode, o_run_enable;
  logic [31:0] o_ratio_value;
  logic [31:0] r [4];
  logic [5:0] o_ratio_frac_bits;
  logic [2:0] o_input_loop_min_bandwidth;
  logic [7:0] q [$];
  int err_count = 0, tests_run = 0;
  pll_ratio_format_and_bandwidth_cfg i_pll_ratio_format_and_bandwidth_cfg (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .i_auto_switch_en(i_auto_switch_en),
    .i_auto_hybrid_sel(i_auto_hybrid_sel), .i_locked(i_locked), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_ratio_value(o_ratio_value), .o_ratio_frac_bits(o_ratio_frac_bits), .o_hybrid_mode(o_hybrid_mode),
    .o_input_loop_min_bandwidth(o_input_loop_min_bandwidth), .o_min_bandwidth_hz(o_min_bandwidth_hz),
    .o_run_enable(o_run_enable));
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // tasks start and end 1 ns after an edge and leave one idle edge, so a strobe never toggles twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wr = 1;
    i_addr = a;
    i_wdata = d;
    @(posedge i_clk);
    #1 i_wr = 0;
    @(posedge i_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    i_rd = 1;
    i_addr = a;
    @(posedge i_clk);
    #1 i_rd = 0;
    @(posedge i_clk);
    #1;
  endtask : rd
  // derived outputs land one edge after the write edge
  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // read answers are matched in order against the notes left by rd, mid-cycle where they have settled
  always @(negedge i_clk) begin
    if (i_rst_b && o_rvalid) begin
      if (q.size() == 0) begin
        err_count++;
        $display("[ERR] rdata exp none got %h", o_rdata);
      end else `CHK("rdata", q.pop_front(), o_rdata)
    end
  end
  initial begin
    repeat (20) @(posedge i_clk);
    #1 i_rst_b = 1;
    `CHK("frac_rst", 6'd20, o_ratio_frac_bits)
    `CHK("hz_rst", 8'h01, o_min_bandwidth_hz)
    for (int i = 0; i < 4; i++) begin
      for (int b = 0; b < 4; b++) begin
        seed = lfsr(seed);
        wr(8'h06 + 8'(4 * i + b), seed);
        r[i] = {r[i][23:0], seed};
      end
    end
    // two ratios carry worked scaled values, one per format
    for (int b = 0; b < 4; b++) begin
      wr(8'h06 + 8'(b), 8'(32'h0013a92a >> (24 - 8 * b)));
      wr(8'h0a + 8'(b), 8'(32'h32000000 >> (24 - 8 * b)));
    end
    r[0] = 32'h0013a92a;
    r[1] = 32'h32000000;
    wr(8'h1e, 8'h20);
    wr(8'h05, 8'h01);
    settle();
    `CHK("run_one", 1'b0, o_run_enable)
    `CHK("bw_pre", 3'h2, o_input_loop_min_bandwidth)
    for (int f = 0; f < 2; f++) begin
      wr(8'h17, 8'(f << 3));
      for (int s = 0; s < 2; s++) begin
        for (int i = 0; i < 4; i++) begin
          wr(8'h03, 8'h80 | 8'(i << 1) | 8'(s));
          settle();
          `CHK("run", 1'b1, o_run_enable)
          `CHK("ratio", r[i], o_ratio_value)
          `CHK("hybrid", 1'(s), o_hybrid_mode)
          `CHK("frac", (s == 1 && f == 0) ? 6'd12 : 6'd20, o_ratio_frac_bits)
        end
      end
    end
    wr(8'h03, 8'h80); // manual static, so only auto switching can pick hybrid
    i_auto_switch_en = 1;
    i_auto_hybrid_sel = 1;
    settle();
    `CHK("auto_hy", 1'b1, o_hybrid_mode)
    i_auto_hybrid_sel = 0;
    settle();
    `CHK("auto_st", 1'b0, o_hybrid_mode)
    for (int c = 0; c < 8; c++) begin
      wr(8'h1e, 8'h8f | 8'(c << 4));
      settle();
      `CHK("bw", 3'(c), o_input_loop_min_bandwidth)
      `CHK("hz", 8'h01 << c, o_min_bandwidth_hz)
      rd(8'h1e, 8'(c << 4));
    end
    i_locked = 1;
    wr(8'h1e, 8'h30);
    settle();
    `CHK("bw_lock", 3'h7, o_input_loop_min_bandwidth)
    `CHK("hz_lock", 8'h80, o_min_bandwidth_hz)
    rd(8'h1e, 8'h30);
    rd(8'hff, 8'h00);
    i_locked = 0; // input clock removed and restored, dropping lock
    settle();
    `CHK("bw_unlock", 3'h3, o_input_loop_min_bandwidth)
    `CHK("hz_unlock", 8'h08, o_min_bandwidth_hz)
    for (int k = 0; k < 8 && q.size() > 0; k++) @(posedge i_clk);
    if (q.size() > 0) begin
      err_count++;
      $display("[ERR] pending_reads exp 0 got %0d", q.size());
    end
    test_done();
  end
endmodule : pll_ratio_format_and_bandwidth_cfg_tb
`default_nettype wire

// ---- design/pll_ratio_consts.svh ----
// register offsets, field positions, reset values and fraction widths for the ratio format block
`ifndef PLL_RATIO_CONSTS_SVH
`define PLL_RATIO_CONSTS_SVH
`define RATIO_BASE_ADDR 8'h06
`define FUNC_CFG_TWO_ADDR 8'h17
`define FUNC_CFG_THREE_ADDR 8'h1e
`define DEV_CTRL_CFG_ADDR 8'h03
`define GLOBAL_CFG_ADDR 8'h05
`define DEV_CFG_ENABLE_ONE_ADDR 8'h03
`define LF_RATIO_FMT_BIT 3
`define SRC_SELECT_BIT 0
`define RATIO_INDEX_LSB 1
`define BW_LSB 4
`define BW_MSB 6
`define CFG_ENABLE_TWO_BIT 0
`define CFG_ENABLE_ONE_BIT 7
`define FUNC_CFG_THREE_MASK 8'h70
`define FUNC_CFG_THREE_RESET 8'h00
`define BYTE_RESET 8'h00
`define FRAC_BITS_HIGH_MULT 12
`define FRAC_BITS_HIGH_ACC 20
`endif

// ---- design/pll_ratio_format_and_bandwidth_cfg.sv ----
// register file and ratio decode for the fractional-n pll format and input bandwidth settings
// Overview of operation
// - in the dynamic hybrid mode the selected ratio is 20.12 when the format bit is 0 and 12.20 when it is 1.
// - in the static synthesizer mode the selected ratio is always 12.20 and the format bit is ignored.
// - the three-bit bandwidth code sets the minimum loop bandwidth as two to the code in hertz, 1 Hz to 128 Hz.
// - the third function configuration register sits at 1eh with the code in bits 6 to 4 and the rest reserved.
// - a new bandwidth code is only applied while the loop is unlocked, so software writes it before lock.
// - each user ratio is four consecutive byte registers, first one most significant.
// - the two-bit ratio index picks ratio 0 to 3 in both the static and the dynamic hybrid mode.
// - with automatic switching off, the source select bit picks static mode at 0 and dynamic mode at 1.
// - normal operation starts only once both configuration enable bits are set, in either order.
`timescale 1ns/100ps
`default_nettype none
`include "pll_ratio_consts.svh"
module pll_ratio_format_and_bandwidth_cfg #(
  parameter int NUM_RATIOS = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_auto_switch_en,
  input wire logic i_auto_hybrid_sel,
  input wire logic i_locked,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic [31:0] o_ratio_value,
  output logic [5:0] o_ratio_frac_bits,
  output logic o_hybrid_mode,
  output logic [2:0] o_input_loop_min_bandwidth,
  output logic [7:0] o_min_bandwidth_hz,
  output logic o_run_enable
);
  logic [31:0] user_ratio_value [NUM_RATIOS];
  logic synth_source_select;
  logic [1:0] ratio_index_select;
  logic low_freq_ratio_format;
  logic [2:0] bw_code;
  logic [2:0] bw_applied_code;
  logic cfg_enable_one;
  logic cfg_enable_two;
  logic [7:0] rdata;
  logic rvalid;
  logic [31:0] ratio_value;
  logic [5:0] frac_bits;
  logic hybrid;
  logic run_enable;
  logic next_synth_source_select;
  logic [1:0] next_ratio_index_select;
  logic next_low_freq_ratio_format;
  logic [2:0] next_bw_code;
  logic [2:0] next_bw_applied_code;
  logic next_cfg_enable_one;
  logic next_cfg_enable_two;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic [31:0] next_ratio_value;
  logic [5:0] next_frac_bits;
  logic next_hybrid;
  logic next_run_enable;
  pll_ratio_pkg::pll_mode_type mode;
  pll_ratio_pkg::ratio_format_type fmt;
  // ratio reads index the store by offset from the first ratio byte, sized to the ratio count
  localparam int IDX_W = $clog2(NUM_RATIOS);
  logic [7:0] ratio_offset;
  logic [7:0] bw_hz;
  logic [7:0] next_bw_hz;

  genvar g;
  generate
    for (g = 0; g < NUM_RATIOS; g++) begin : g_ratio
      ratio_byte_store #(
        .BASE(8'(`RATIO_BASE_ADDR + 4 * g))
      ) i_ratio_byte_store (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_wr(i_wr),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .o_value(user_ratio_value[g])
      );
    end
  endgenerate

  // register writes
  always_comb begin
    next_synth_source_select = synth_source_select;
    next_ratio_index_select = ratio_index_select;
    next_low_freq_ratio_format = low_freq_ratio_format;
    next_bw_code = bw_code;
    next_cfg_enable_one = cfg_enable_one;
    next_cfg_enable_two = cfg_enable_two;
    if (i_wr) begin
      if (i_addr == `DEV_CTRL_CFG_ADDR) begin
        next_synth_source_select = i_wdata[`SRC_SELECT_BIT];
        next_ratio_index_select = i_wdata[`RATIO_INDEX_LSB +: 2];
        next_cfg_enable_one = i_wdata[`CFG_ENABLE_ONE_BIT];
      end else if (i_addr == `GLOBAL_CFG_ADDR) begin
        next_cfg_enable_two = i_wdata[`CFG_ENABLE_TWO_BIT];
      end else if (i_addr == `FUNC_CFG_TWO_ADDR) begin
        next_low_freq_ratio_format = i_wdata[`LF_RATIO_FMT_BIT];
      end else if (i_addr == `FUNC_CFG_THREE_ADDR) begin
        // only bits 6..4 are stored
        next_bw_code = i_wdata[`BW_MSB:`BW_LSB];
      end
    end
  end

  // read mux
  assign ratio_offset = 8'(i_addr - `RATIO_BASE_ADDR);
  always_comb begin
    next_rdata = 8'h00;
    next_rvalid = i_rd;
    if (i_addr == `DEV_CTRL_CFG_ADDR) begin
      next_rdata = {cfg_enable_one, 4'h0, ratio_index_select, synth_source_select};
    end else if (i_addr == `GLOBAL_CFG_ADDR) begin
      next_rdata = {7'h00, cfg_enable_two};
    end else if (i_addr == `FUNC_CFG_TWO_ADDR) begin
      next_rdata = {4'h0, low_freq_ratio_format, 3'h0};
    end else if (i_addr == `FUNC_CFG_THREE_ADDR) begin
      next_rdata = {1'b0, bw_code, 4'h0}; // reserved bits read zero
    end else if (i_addr >= `RATIO_BASE_ADDR && i_addr < 8'(`RATIO_BASE_ADDR + 4 * NUM_RATIOS)) begin
      next_rdata = 8'(user_ratio_value[ratio_offset[IDX_W + 1:2]] >> {~ratio_offset[1:0], 3'h0});
    end
    if (!i_rd) begin
      next_rdata = rdata;
    end
  end

  // mode, format and ratio decode
  always_comb begin
    // manual choice only when auto switching is off
    if (i_auto_switch_en) begin
      mode = i_auto_hybrid_sel ? pll_ratio_pkg::hybrid_dynamic : pll_ratio_pkg::synth_static;
    end else begin
      mode = synth_source_select ? pll_ratio_pkg::hybrid_dynamic : pll_ratio_pkg::synth_static;
    end
    case (mode)
      pll_ratio_pkg::hybrid_dynamic: begin
        fmt = low_freq_ratio_format ? pll_ratio_pkg::fmt_12_20 : pll_ratio_pkg::fmt_20_12;
      end
      default: begin
        fmt = pll_ratio_pkg::fmt_12_20; // format bit ignored
      end
    endcase
    // decoded fresh each cycle, so a mode change needs no ratio rewrite
    next_frac_bits = (fmt == pll_ratio_pkg::fmt_12_20) ? 6'(`FRAC_BITS_HIGH_ACC) : 6'(`FRAC_BITS_HIGH_MULT);
    next_ratio_value = user_ratio_value[ratio_index_select];
    next_hybrid = (mode == pll_ratio_pkg::hybrid_dynamic);
    next_run_enable = cfg_enable_one & cfg_enable_two;
  end

  // applied bandwidth follows the written code only while unlocked; once locked it holds
  always_comb begin
    next_bw_applied_code = bw_applied_code;
    if (!i_locked) begin
      next_bw_applied_code = bw_code;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      synth_source_select <= 1'b0;
      ratio_index_select <= 2'h0;
      low_freq_ratio_format <= 1'b0;
      bw_code <= 3'h0;
      bw_applied_code <= 3'h0;
      cfg_enable_one <= 1'b0;
      cfg_enable_two <= 1'b0;
      rdata <= 8'h00;
      rvalid <= 1'b0;
      ratio_value <= 32'h0;
      frac_bits <= 6'(`FRAC_BITS_HIGH_ACC);
      hybrid <= 1'b0;
      run_enable <= 1'b0;
    end else begin
      synth_source_select <= next_synth_source_select;
      ratio_index_select <= next_ratio_index_select;
      low_freq_ratio_format <= next_low_freq_ratio_format;
      bw_code <= next_bw_code;
      bw_applied_code <= next_bw_applied_code;
      cfg_enable_one <= next_cfg_enable_one;
      cfg_enable_two <= next_cfg_enable_two;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      ratio_value <= next_ratio_value;
      frac_bits <= next_frac_bits;
      hybrid <= next_hybrid;
      run_enable <= next_run_enable;
    end
  end

  // bandwidth in hertz is two to the applied code
  always_comb begin
    next_bw_hz = 8'(8'h01 << next_bw_applied_code);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bw_hz <= 8'h01;
    end else begin
      bw_hz <= next_bw_hz;
    end
  end

  assign o_rdata = rdata;
  assign o_rvalid = rvalid;
  assign o_ratio_value = ratio_value;
  assign o_ratio_frac_bits = frac_bits;
  assign o_hybrid_mode = hybrid;
  assign o_input_loop_min_bandwidth = bw_applied_code;
  assign o_min_bandwidth_hz = bw_hz;
  assign o_run_enable = run_enable;
endmodule : pll_ratio_format_and_bandwidth_cfg
`default_nettype wire

// ---- design/pll_ratio_pkg.sv ----
// types shared by the ratio format block
`default_nettype none
package pll_ratio_pkg;
  typedef enum logic [1:0] {
    synth_static,
    hybrid_dynamic
  } pll_mode_type;
  typedef enum logic {
    fmt_20_12,
    fmt_12_20
  } ratio_format_type;
  typedef enum logic [1:0] {
    bw_idle,
    bw_applied
  } bw_state_type;
endpackage : pll_ratio_pkg
`default_nettype wire

// ---- design/ratio_byte_store.sv ----
// one stored 32-bit user ratio built from four byte registers
`timescale 1ns/100ps
`default_nettype none
`include "pll_ratio_consts.svh"
module ratio_byte_store #(
  parameter logic [7:0] BASE = 8'h06
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [31:0] o_value
);
  logic [31:0] value;
  logic [31:0] next_value;
  always_comb begin
    next_value = value;
    if (i_wr) begin
      // first address holds the most significant byte
      if (i_addr == BASE) begin
        next_value[31:24] = i_wdata;
      end else if (i_addr == BASE + 8'h01) begin
        next_value[23:16] = i_wdata;
      end else if (i_addr == BASE + 8'h02) begin
        next_value[15:8] = i_wdata;
      end else if (i_addr == BASE + 8'h03) begin
        next_value[7:0] = i_wdata;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      value <= {4{`BYTE_RESET}};
    end else begin
      value <= next_value;
    end
  end
  assign o_value = value;
endmodule : ratio_byte_store
`default_nettype wire
